// ===== rtl/tge_engine.sv
/*
  Text glyph and cursor engine: AXI4-Lite register file, user glyph fetch
  and render, text input position with line wrap, text and graphic cursors.
  Assumes glyph memory answers each read with one byte in i_mem_rdata,
  one byte per request, and a frame pulse from the display timing logic.
*/
`timescale 1ns/1ps
module tge_engine
  import tge_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [9:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [9:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output tge_pkg::tge_mem_req_t o_mem_req,
  input wire logic i_mem_rvalid,
  input wire logic [7:0] i_mem_rdata,
  output tge_pkg::tge_pix_t o_pix,
  input wire logic i_frame,
  output logic o_text_cursor_show,
  output logic [15:0] o_text_cursor_w,
  output logic [15:0] o_text_cursor_h,
  output logic o_gfx_cursor_show,
  output logic [15:0] o_gfx_cursor_x,
  output logic [15:0] o_gfx_cursor_y,
  output logic [9:0] o_gfx_cursor_base,
  output logic o_pip_allow,
  input wire logic [1:0] i_gcur_index,
  output logic [23:0] o_gcur_colour
);
  import tge_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [7:0] regs_q [0:255];
  logic [7:0] regs_d [0:255];
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, bvalid_q, bvalid_d;
  logic [7:0] aw_idx_q, aw_idx_d;
  logic [7:0] wbyte_q, wbyte_d;
  logic wen_q, wen_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d, bresp_q, bresp_d;
  logic wr_fire;
  logic code_wr;

  function automatic logic mapped(input logic [7:0] idx);
    case (idx)
      IDX_INPUT_CONTROL, IDX_CURSOR_CONTROL, IDX_BLINK_INTERVAL, IDX_TCUR_HSIZE,
      IDX_TCUR_VSIZE, IDX_GCUR_X_LOW, IDX_GCUR_X_HIGH, IDX_GCUR_Y_LOW,
      IDX_GCUR_Y_HIGH, IDX_GCUR_COLOUR_ZERO, IDX_GCUR_COLOUR_ONE, IDX_TEXT_X_LOW,
      IDX_TEXT_X_HIGH, IDX_TEXT_Y_LOW, IDX_TEXT_Y_HIGH, IDX_CHAR_CONTROL,
      IDX_LINE_GAP, IDX_SCAN_CONTROL, IDX_GLYPH_FORMAT, IDX_GLYPH_BASE_0,
      IDX_GLYPH_BASE_1, IDX_GLYPH_BASE_2, IDX_GLYPH_BASE_3, IDX_GLYPH_CODE_LOW,
      IDX_GLYPH_CODE_HIGH, IDX_ENGINE_STATUS, IDX_WIN_WIDTH_LOW, IDX_WIN_WIDTH_HIGH,
      IDX_WIN_HEIGHT_LOW, IDX_WIN_HEIGHT_HIGH,
      IDX_FG_COLOUR, IDX_FG_COLOUR + 8'd1, IDX_FG_COLOUR + 8'd2,
      IDX_BG_COLOUR, IDX_BG_COLOUR + 8'd1, IDX_BG_COLOUR + 8'd2:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  endfunction

  assign o_awready = !aw_hold_q && !bvalid_q;
  assign o_wready = !w_hold_q && !bvalid_q;
  assign o_arready = !rvalid_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;
  assign wr_fire = (aw_hold_q || (i_awvalid && o_awready))
                 && (w_hold_q || (i_wvalid && o_wready)) && !bvalid_q;

  always_comb
  begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    aw_idx_d = aw_idx_q;
    wbyte_d = wbyte_q;
    wen_d = wen_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (i_awvalid && o_awready)
    begin
      aw_hold_d = 1'b1;
      aw_idx_d = i_awaddr[9:2];
    end
    if (i_wvalid && o_wready)
    begin
      w_hold_d = 1'b1;
      wbyte_d = i_wdata[7:0];
      wen_d = i_wstrb[0];
    end
    if (wr_fire)
    begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = mapped(aw_idx_d) ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_q && i_bready)
    begin
      bvalid_d = 1'b0;
    end
  end

  // Write commit in the same cycle that both channels are accepted or held
  logic commit;
  logic [7:0] commit_idx;
  logic [7:0] commit_byte;
  assign commit = wr_fire;
  assign commit_idx = (i_awvalid && o_awready) ? i_awaddr[9:2] : aw_idx_q;
  assign commit_byte = (i_wvalid && o_wready) ? i_wdata[7:0] : wbyte_q;
  logic commit_en;
  assign commit_en = (i_wvalid && o_wready) ? i_wstrb[0] : wen_q;
  assign code_wr = commit && commit_en && (commit_idx == IDX_GLYPH_CODE_HIGH);

  always_comb
  begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (i_arvalid && o_arready)
    begin
      rvalid_d = 1'b1;
      rdata_d = {24'h000000, regs_q[i_araddr[9:2]]};
      rresp_d = mapped(i_araddr[9:2]) ? RESP_OKAY : RESP_SLVERR;
      if (!mapped(i_araddr[9:2]))
      begin
        rdata_d = 32'h00000000;
      end
    end
    else if (rvalid_q && i_rready)
    begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_idx_q <= 8'h00;
      wbyte_q <= 8'h00;
      wen_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end
    else
    begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      aw_idx_q <= aw_idx_d;
      wbyte_q <= wbyte_d;
      wen_q <= wen_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control fields
  logic text_mode, vertical_scan_direction_up, rotate, transp, full_align, tcur_en, blink_en;
  logic [1:0] gfmt;
  logic [2:0] mag_w, mag_h;
  logic [15:0] win_w, win_h;
  logic [31:0] glyph_base;
  logic [15:0] glyph_code;
  logic [23:0] fg_colour, bg_colour;
  logic [7:0] glyph_bytes;
  logic [4:0] glyph_w, glyph_h;
  logic busy;

  assign text_mode = regs_q[IDX_INPUT_CONTROL][TEXT_MODE_BIT];
  assign vertical_scan_direction_up = regs_q[IDX_SCAN_CONTROL][VERTICAL_SCAN_DIRECTION_BIT];
  assign rotate = regs_q[IDX_CHAR_CONTROL][ROTATE_BIT];
  assign transp = regs_q[IDX_CHAR_CONTROL][TRANSP_BIT];
  assign full_align = regs_q[IDX_CHAR_CONTROL][FULL_ALIGN_BIT];
  assign tcur_en = regs_q[IDX_CURSOR_CONTROL][TCUR_EN_BIT];
  assign blink_en = regs_q[IDX_CURSOR_CONTROL][TCUR_BLINK_BIT];
  assign mag_w = {1'b0, regs_q[IDX_CHAR_CONTROL][3:2]} + 3'd1;
  assign mag_h = {1'b0, regs_q[IDX_CHAR_CONTROL][1:0]} + 3'd1;
  assign gfmt = regs_q[IDX_GLYPH_FORMAT][1:0];
  assign win_w = {regs_q[IDX_WIN_WIDTH_HIGH], regs_q[IDX_WIN_WIDTH_LOW]};
  assign win_h = {regs_q[IDX_WIN_HEIGHT_HIGH], regs_q[IDX_WIN_HEIGHT_LOW]};
  assign glyph_base = {regs_q[IDX_GLYPH_BASE_3], regs_q[IDX_GLYPH_BASE_2],
                       regs_q[IDX_GLYPH_BASE_1], regs_q[IDX_GLYPH_BASE_0]};
  assign glyph_code = {regs_q[IDX_GLYPH_CODE_HIGH], regs_q[IDX_GLYPH_CODE_LOW]};
  assign fg_colour = {regs_q[IDX_FG_COLOUR + 8'd2], regs_q[IDX_FG_COLOUR + 8'd1],
                      regs_q[IDX_FG_COLOUR]};
  assign bg_colour = {regs_q[IDX_BG_COLOUR + 8'd2], regs_q[IDX_BG_COLOUR + 8'd1],
                      regs_q[IDX_BG_COLOUR]};

  // byte count and shape per format
  always_comb
  begin
    case (gfmt)
      FMT_16X32:
      begin
        glyph_bytes = BYTES_16X32;
        glyph_w = 5'd15;
        glyph_h = 5'd31;
      end
      FMT_32X32:
      begin
        glyph_bytes = BYTES_32X32;
        glyph_w = 5'd31;
        glyph_h = 5'd31;
      end
      default:
      begin
        glyph_bytes = BYTES_24X24;
        glyph_w = 5'd23;
        glyph_h = 5'd23;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Glyph engine
  tge_state_t st_q, st_d;
  logic [7:0] byte_q, byte_d;
  logic [31:0] gaddr_q, gaddr_d;
  logic req_q, req_d;
  logic [7:0] bits_q, bits_d;
  logic [3:0] bit_q, bit_d;
  logic [9:0] px_q, px_d;
  logic [15:0] cx_q, cy_q, cx_d, cy_d;
  tge_pix_t pix_q, pix_d;
  logic [15:0] adv_w, adv_h, line_step;
  logic [4:0] col, row;
  logic set_pos_x, set_pos_y;

  assign busy = (st_q != TGE_IDLE);
  // half width glyphs take a half advance only without alignment
  assign adv_w = (glyph_code < FULL_WIDTH_CODE && !full_align)
               ? 16'(({11'd0, glyph_w} + 16'd1) >> 1) * 16'(mag_w)
               : 16'({11'd0, glyph_w} + 16'd1) * 16'(mag_w);
  // line gap added to line pitch
  assign adv_h = 16'({11'd0, glyph_h} + 16'd1) * 16'(mag_h);
  assign line_step = adv_h + 16'(regs_q[IDX_LINE_GAP]);
  assign col = 5'(px_q % (10'(glyph_w) + 10'd1));
  assign row = 5'(px_q / (10'(glyph_w) + 10'd1));
  assign set_pos_x = commit && commit_en
                   && (commit_idx == IDX_TEXT_X_LOW || commit_idx == IDX_TEXT_X_HIGH);
  assign set_pos_y = commit && commit_en
                   && (commit_idx == IDX_TEXT_Y_LOW || commit_idx == IDX_TEXT_Y_HIGH);

  always_comb
  begin
    st_d = st_q;
    byte_d = byte_q;
    gaddr_d = gaddr_q;
    req_d = 1'b0;
    bits_d = bits_q;
    bit_d = bit_q;
    px_d = px_q;
    cx_d = cx_q;
    cy_d = cy_q;
    pix_d = '0;
    case (st_q)
      TGE_IDLE:
      begin
        // glyphs rendered only in text mode
        if (code_wr && text_mode)
        begin
          st_d = TGE_FETCH;
          byte_d = 8'd0;
          bit_d = 4'd8;
          px_d = 10'd0;
          // table base plus code times glyph size
          gaddr_d = glyph_base + 32'({commit_byte, regs_q[IDX_GLYPH_CODE_LOW]})
                  * 32'(glyph_bytes);
          req_d = 1'b1;
        end
      end
      TGE_FETCH:
      begin
        if (bit_q == 4'd8)
        begin
          if (i_mem_rvalid)
          begin
            bits_d = i_mem_rdata;
            bit_d = 4'd0;
            byte_d = byte_q + 8'd1;
          end
        end
        else
        begin
          // Bit 7 of each byte is the leftmost pixel
          // background skipped when transparent
          if (bits_q[3'd7 - bit_q[2:0]] || !transp)
          begin
            pix_d.valid = 1'b1;
            pix_d.colour = bits_q[3'd7 - bit_q[2:0]] ? fg_colour : bg_colour;
            // rotated glyph: column and row swapped
            pix_d.x = rotate ? cx_q + 16'(row) : cx_q + 16'(col);
            pix_d.y = rotate ? cy_q + 16'(col) : cy_q + 16'(row);
          end
          px_d = px_q + 10'd1;
          bit_d = bit_q + 4'd1;
          if (bit_q == 4'd7)
          begin
            bit_d = 4'd8;
            if (byte_q == glyph_bytes)
            begin
              st_d = TGE_ADVANCE;
            end
            else
            begin
              gaddr_d = gaddr_q + 32'd1;
              req_d = 1'b1;
            end
          end
        end
      end
      TGE_ADVANCE:
      begin
        st_d = TGE_IDLE;
        // advance with wrap at window edge
        if (!rotate)
        begin
          if (cx_q + adv_w + adv_w > win_w)
          begin
            cx_d = 16'd0;
            cy_d = cy_q + line_step;
          end
          else
          begin
            cx_d = cx_q + adv_w;
          end
        end
        else if (cy_q + adv_w + adv_w > win_h)
        begin
          cy_d = 16'd0;
          cx_d = cx_q + line_step;
        end
        else
        begin
          cy_d = cy_q + adv_w;
        end
      end
      default:
      begin
        st_d = TGE_IDLE;
      end
    endcase
    if (set_pos_x)
    begin
      cx_d = (commit_idx == IDX_TEXT_X_LOW) ? {cx_q[15:8], commit_byte}
                                            : {commit_byte, cx_q[7:0]};
    end
    if (set_pos_y)
    begin
      cy_d = (commit_idx == IDX_TEXT_Y_LOW) ? {cy_q[15:8], commit_byte}
                                            : {commit_byte, cy_q[7:0]};
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      st_q <= TGE_IDLE;
      byte_q <= 8'd0;
      gaddr_q <= 32'd0;
      req_q <= 1'b0;
      bits_q <= 8'd0;
      bit_q <= 4'd8;
      px_q <= 10'd0;
      cx_q <= 16'd0;
      cy_q <= 16'd0;
      pix_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      byte_q <= byte_d;
      gaddr_q <= gaddr_d;
      req_q <= req_d;
      bits_q <= bits_d;
      bit_q <= bit_d;
      px_q <= px_d;
      cx_q <= cx_d;
      cy_q <= cy_d;
      pix_q <= pix_d;
    end
  end

  assign o_mem_req.valid = req_q;
  assign o_mem_req.addr = gaddr_q;
  assign o_pix = pix_q;

  // Register array next values; position and status mirror engine state
  always_comb
  begin
    for (int i = 0; i < 256; i++)
    begin
      regs_d[i] = regs_q[i];
    end
    if (commit && commit_en && mapped(commit_idx) && commit_idx != IDX_ENGINE_STATUS)
    begin
      regs_d[commit_idx] = commit_byte;
    end
    regs_d[IDX_TEXT_X_LOW] = cx_d[7:0];
    regs_d[IDX_TEXT_X_HIGH] = cx_d[15:8];
    regs_d[IDX_TEXT_Y_LOW] = cy_d[7:0];
    regs_d[IDX_TEXT_Y_HIGH] = cy_d[15:8];
    regs_d[IDX_ENGINE_STATUS] = {7'd0, st_d != TGE_IDLE};
  end

  always_ff @(posedge i_ref_clk)
  begin
    for (int i = 0; i < 256; i++)
    begin
      if (i_srst)
      begin
        case (8'(i))
          IDX_BLINK_INTERVAL: regs_q[i] <= RST_BLINK;
          IDX_TCUR_HSIZE, IDX_TCUR_VSIZE: regs_q[i] <= RST_TCUR_SIZE;
          IDX_WIN_WIDTH_HIGH, IDX_WIN_HEIGHT_HIGH: regs_q[i] <= RST_WIN[15:8];
          default: regs_q[i] <= RST_ZERO;
        endcase
      end
      else
      begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cursors
  logic [7:0] frames_q, frames_d;
  logic phase_q, phase_d;
  logic [23:0] gcol_q, gcol_d;

  always_comb
  begin
    frames_d = frames_q;
    phase_d = phase_q;
    if (!blink_en)
    begin
      frames_d = 8'd0;
      phase_d = 1'b1;
    end
    else if (i_frame)
    begin
      frames_d = frames_q + 8'd1;
      if (frames_q + 8'd1 >= regs_q[IDX_BLINK_INTERVAL])
      begin
        frames_d = 8'd0;
        phase_d = !phase_q;
      end
    end
    case (i_gcur_index)
      2'b00: gcol_d = {16'h0000, regs_q[IDX_GCUR_COLOUR_ZERO]};
      2'b01: gcol_d = {16'h0000, regs_q[IDX_GCUR_COLOUR_ONE]};
      2'b10: gcol_d = bg_colour;
      default: gcol_d = ~bg_colour;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      frames_q <= 8'd0;
      phase_q <= 1'b1;
      gcol_q <= 24'h000000;
    end
    else
    begin
      frames_q <= frames_d;
      phase_q <= phase_d;
      gcol_q <= gcol_d;
    end
  end

  assign o_text_cursor_show = tcur_en && text_mode && !vertical_scan_direction_up && phase_q;
  assign o_gfx_cursor_show = regs_q[IDX_CURSOR_CONTROL][GCUR_EN_BIT] && !vertical_scan_direction_up;
  assign o_pip_allow = regs_q[IDX_SCAN_CONTROL][PIP_EN_BIT] && !vertical_scan_direction_up;
  assign o_text_cursor_w = 16'(regs_q[IDX_TCUR_HSIZE]) * 16'(mag_w);
  assign o_text_cursor_h = 16'(regs_q[IDX_TCUR_VSIZE]) * 16'(mag_h);
  assign o_gfx_cursor_x = {regs_q[IDX_GCUR_X_HIGH], regs_q[IDX_GCUR_X_LOW]};
  assign o_gfx_cursor_y = {regs_q[IDX_GCUR_Y_HIGH], regs_q[IDX_GCUR_Y_LOW]};
  assign o_gfx_cursor_base = 10'(regs_q[IDX_CURSOR_CONTROL][GCUR_SEL_LSB +: 2])
                           * GCUR_IMAGE_BYTES;
  assign o_gcur_colour = gcol_q;
endmodule

// ===== rtl/tge_pkg.sv
/*
  Package for the text glyph and cursor engine: register offsets, field
  positions, reset values, glyph sizes and shared structs.
  Assumes an AXI4-Lite master with 32-bit data in front of the register file.
*/
package tge_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_INPUT_CONTROL = 8'h03;
  localparam logic [7:0] IDX_CURSOR_CONTROL = 8'h3c;
  localparam logic [7:0] IDX_BLINK_INTERVAL = 8'h3d;
  localparam logic [7:0] IDX_TCUR_HSIZE = 8'h3e;
  localparam logic [7:0] IDX_TCUR_VSIZE = 8'h3f;
  localparam logic [7:0] IDX_GCUR_X_LOW = 8'h40;
  localparam logic [7:0] IDX_GCUR_X_HIGH = 8'h41;
  localparam logic [7:0] IDX_GCUR_Y_LOW = 8'h42;
  localparam logic [7:0] IDX_GCUR_Y_HIGH = 8'h43;
  localparam logic [7:0] IDX_GCUR_COLOUR_ZERO = 8'h44;
  localparam logic [7:0] IDX_GCUR_COLOUR_ONE = 8'h45;
  localparam logic [7:0] IDX_TEXT_X_LOW = 8'h63;
  localparam logic [7:0] IDX_TEXT_X_HIGH = 8'h64;
  localparam logic [7:0] IDX_TEXT_Y_LOW = 8'h65;
  localparam logic [7:0] IDX_TEXT_Y_HIGH = 8'h66;
  localparam logic [7:0] IDX_CHAR_CONTROL = 8'hcd;
  localparam logic [7:0] IDX_LINE_GAP = 8'hd0;
  // Own registers
  localparam logic [7:0] IDX_SCAN_CONTROL = 8'h12;
  localparam logic [7:0] IDX_GLYPH_FORMAT = 8'hc0;
  localparam logic [7:0] IDX_GLYPH_BASE_0 = 8'hc1;
  localparam logic [7:0] IDX_GLYPH_BASE_1 = 8'hc2;
  localparam logic [7:0] IDX_GLYPH_BASE_2 = 8'hc3;
  localparam logic [7:0] IDX_GLYPH_BASE_3 = 8'hc4;
  localparam logic [7:0] IDX_GLYPH_CODE_LOW = 8'hc5;
  localparam logic [7:0] IDX_GLYPH_CODE_HIGH = 8'hc6;
  localparam logic [7:0] IDX_ENGINE_STATUS = 8'hc7;
  localparam logic [7:0] IDX_WIN_WIDTH_LOW = 8'hc8;
  localparam logic [7:0] IDX_WIN_WIDTH_HIGH = 8'hc9;
  localparam logic [7:0] IDX_WIN_HEIGHT_LOW = 8'hca;
  localparam logic [7:0] IDX_WIN_HEIGHT_HIGH = 8'hcb;
  localparam logic [7:0] IDX_FG_COLOUR = 8'hd2;
  localparam logic [7:0] IDX_BG_COLOUR = 8'hd5;

  // Field positions
  localparam int TEXT_MODE_BIT = 2;
  localparam int TCUR_EN_BIT = 1;
  localparam int TCUR_BLINK_BIT = 0;
  localparam int GCUR_SEL_LSB = 2;
  localparam int GCUR_EN_BIT = 4;
  localparam int VERTICAL_SCAN_DIRECTION_BIT = 3;
  localparam int PIP_EN_BIT = 7;
  localparam int ROTATE_BIT = 4;
  localparam int TRANSP_BIT = 6;
  localparam int FULL_ALIGN_BIT = 7;

  // Glyph formats and byte counts
  localparam logic [1:0] FMT_24X24 = 2'd0;
  localparam logic [1:0] FMT_16X32 = 2'd1;
  localparam logic [1:0] FMT_32X32 = 2'd2;
  localparam logic [7:0] BYTES_24X24 = 8'd72;
  localparam logic [7:0] BYTES_16X32 = 8'd64;
  localparam logic [7:0] BYTES_32X32 = 8'd128;
  localparam logic [15:0] FULL_WIDTH_CODE = 16'h8000;
  localparam logic [9:0] GCUR_IMAGE_BYTES = 10'd256;

  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_BLINK = 8'h10;
  localparam logic [7:0] RST_TCUR_SIZE = 8'h08;
  localparam logic [15:0] RST_WIN = 16'h0100;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    TGE_IDLE = 2'b00,
    TGE_FETCH = 2'b01,
    TGE_ADVANCE = 2'b11
  } tge_state_t;

  // Glyph memory read request
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } tge_mem_req_t;

  // One glyph pixel written to display memory
  typedef struct packed {
    logic valid;
    logic [15:0] x;
    logic [15:0] y;
    logic [23:0] colour;
  } tge_pix_t;
endpackage

// ===== tb/tge_glyph_mem.sv
/* Glyph memory model: answers each byte read three cycles later.
   Assumes at most one read in flight, as the engine issues them. */
`timescale 1ns/1ps
module tge_glyph_mem
  import tge_pkg::*;
(
  input wire logic i_ref_clk,
  input tge_pkg::tge_mem_req_t i_req,
  output logic o_rvalid,
  output logic [7:0] o_rdata
);
  logic [2:0] v_q = 3'h0;
  logic [7:0] d_q [3];
  ////////////////////////////////////////////////////////////////////
  // byte follows address
  always @(posedge i_ref_clk)
  begin
    v_q <= {v_q[1:0], i_req.valid === 1'b1};
    d_q[0] <= i_req.addr[7:0] ^ 8'h5a;
    d_q[1] <= d_q[0];
    d_q[2] <= d_q[1];
  end
  // Idle data line shows the inverse, never a stale byte
  assign o_rvalid = v_q[2];
  assign o_rdata = v_q[2] ? d_q[2] : ~d_q[2];
endmodule

// ===== tb/tge_engine_chk.sv
/* Port checker for the engine: bus answers, fetch pulses, cursor image.
   Assumes it is bound into tge_engine. */
`timescale 1ns/1ps
module tge_engine_chk
  import tge_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [9:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input tge_pkg::tge_mem_req_t o_mem_req,
  input wire logic [9:0] o_gfx_cursor_base,
  input wire logic [1:0] i_gcur_index,
  input wire logic [23:0] o_gcur_colour
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  sequence s_bg_then_inv;
    i_gcur_index == 2'b10 ##1 i_gcur_index == 2'b11;
  endsequence
  property p_w_ans; i_awvalid && o_awready && i_wvalid && o_wready |=> o_bvalid; endproperty
  a_w_ans: assert property (p_w_ans) else $error("write not answered");
  property p_r_ans; i_arvalid && o_arready |=> o_rvalid; endproperty
  a_r_ans: assert property (p_r_ans) else $error("read not answered");
  property p_b_once; o_bvalid && i_bready |=> !o_bvalid; endproperty
  a_b_once: assert property (p_b_once) else $error("second write answer");
  property p_w_block; o_bvalid |-> !o_awready && !o_wready; endproperty
  a_w_block: assert property (p_w_block) else $error("write taken during answer");
  property p_unmapped;
    i_arvalid && o_arready && i_araddr[9:2] == 8'hff |=> o_rresp == RESP_SLVERR && o_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_req_pulse; o_mem_req.valid |=> !o_mem_req.valid; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("glyph read not a pulse");
  property p_gcur_base; o_gfx_cursor_base[7:0] == 8'h00; endproperty
  a_gcur_base: assert property (p_gcur_base) else $error("cursor image misaligned");
  property p_gcur_inv; s_bg_then_inv |=> o_gcur_colour == ~$past(o_gcur_colour); endproperty
  a_gcur_inv: assert property (p_gcur_inv) else $error("inverted colour wrong");
endmodule
bind tge_engine tge_engine_chk i_tge_engine_chk (.i_ref_clk, .i_srst, .i_awvalid, .o_awready,
  .i_wvalid, .o_wready, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
  .o_rresp, .o_rvalid, .o_mem_req, .o_gfx_cursor_base, .i_gcur_index, .o_gcur_colour);

// ===== tb/tb_tge_engine.sv
/* Testbench for the engine: AXI4-Lite register tasks, glyph fetch runs,
   cursor outputs. Assumes the glyph memory model in tge_glyph_mem. */
`timescale 1ns/1ps
module tb_tge_engine;
  import tge_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, frm = 1'b0;
  logic [9:0] awaddr = 10'h000, araddr = 10'h000;
  logic [31:0] wdata = 32'h0, q, first, last;
  logic [1:0] gi = 2'h0, bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid, mrv, tshow, gshow, picture_in_picture;
  logic [31:0] rdata;
  logic [7:0] mrd;
  logic [15:0] tw, gx;
  logic [9:0] gbase;
  logic [23:0] gcol, fg = 24'h0;
  logic [23:0] ce [4] = '{24'h0000a5, 24'h00005a, 24'h000000, 24'hffffff};
  tge_mem_req_t req;
  tge_pix_t pix;
  int err_count = 0, compares = 0, nreq, npix, nfg, pop, bad, k;
  always #20 clk = ~clk;
  tge_engine i_tge_engine (.i_ref_clk(clk), .i_srst(rst), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'h1),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_mem_req(req), .i_mem_rvalid(mrv), .i_mem_rdata(mrd), .o_pix(pix), .i_frame(frm),
    .o_text_cursor_show(tshow), .o_text_cursor_w(tw), .o_text_cursor_h(),
    .o_gfx_cursor_show(gshow), .o_gfx_cursor_x(gx), .o_gfx_cursor_y(),
    .o_gfx_cursor_base(gbase), .o_pip_allow(picture_in_picture), .i_gcur_index(gi), .o_gcur_colour(gcol));
  tge_glyph_mem i_tge_glyph_mem (.i_ref_clk(clk), .i_req(req), .o_rvalid(mrv), .o_rdata(mrd));
  ////////////////////////////////////////////////////////////////////
  // Fetch and pixel monitor
  always @(posedge clk)
  begin
    if (req.valid === 1'b1)
    begin
      if (nreq == 0)
        first = req.addr;
      else if (req.addr !== last + 32'h1)
        bad++;
      last = req.addr;
      nreq++;
      pop += $countones(req.addr[7:0] ^ 8'h5a);
    end
    if (pix.valid === 1'b1)
    begin
      npix++;
      // Background colour is never written, so it stays zero
      if (pix.colour === fg)
        nfg++;
      else if (pix.colour !== 24'h0)
        bad++;
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("Compares %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      err_count++;
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
    logic pa, pw, pr, sa, sw, sr;
    int n;
    pa = 1'b1;
    pw = w;
    pr = 1'b1;
    n = 0;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    araddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    while (pa || pw || pr)
    begin
      @(negedge clk);
      sa = w ? awready : arready;
      sw = wready;
      sr = w ? bvalid : rvalid;
      if (pr && sr)
      begin
        q = rdata;
        r = w ? bresp : rresp;
      end
      @(posedge clk);
      if (pa && sa)
      begin
        pa = 1'b0;
        awvalid <= 1'b0;
        arvalid <= 1'b0;
      end
      if (pw && sw)
      begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
      if (pr && sr)
      begin
        pr = 1'b0;
        bready <= 1'b0;
        rready <= 1'b0;
      end
      n++;
      if (n > 200)
      begin
        err_count++;
        finish_test;
      end
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    acc(1'b1, idx, d);
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    acc(1'b0, idx, 8'h00);
    chk(q, {24'h0, exp});
  endtask
  task automatic glyph(input logic [1:0] fmt, input logic [15:0] code, input int n, input int p);
    int i;
    wr(IDX_GLYPH_FORMAT, {6'h0, fmt});
    wr(IDX_GLYPH_CODE_LOW, code[7:0]);
    nreq = 0;
    npix = 0;
    nfg = 0;
    pop = 0;
    bad = 0;
    wr(IDX_GLYPH_CODE_HIGH, code[15:8]);
    q = 32'h1;
    for (i = 0; i < 2000 && q[0] !== 1'b0; i++)
      acc(1'b0, IDX_ENGINE_STATUS, 8'h00);
    if (q[0] !== 1'b0)
      chk(q, 32'h0);
    chk(first, 32'h1000 + code * n);
    chk(nreq, n);
    chk(bad, 0);
    chk(npix, p < 0 ? pop : p);
    $display("Glyph test done, format %0d", fmt);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdchk(IDX_BLINK_INTERVAL, 8'h10);
    rdchk(IDX_TCUR_HSIZE, 8'h08);
    acc(1'b0, 8'hff, 8'h00);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(IDX_GLYPH_CODE_HIGH, 8'h00);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    repeat (20) @(posedge clk);
    chk(nreq, 0);
    $display("Register test done");
    wr(IDX_INPUT_CONTROL, 8'h04);
    wr(IDX_GLYPH_BASE_1, 8'h10);
    glyph(FMT_24X24, 16'h8001, 72, 576);
    rdchk(IDX_TEXT_X_LOW, 8'd24);
    wr(IDX_LINE_GAP, 8'h04);
    wr(IDX_TEXT_X_LOW, 8'he8);
    glyph(FMT_24X24, 16'h8002, 72, 576);
    rdchk(IDX_TEXT_X_LOW, 8'h00);
    rdchk(IDX_TEXT_Y_LOW, 8'd28);
    wr(IDX_CHAR_CONTROL, 8'h40);
    fg = 24'h333333;
    for (k = 0; k < 3; k++)
      wr(IDX_FG_COLOUR + 8'(k), 8'h33);
    glyph(FMT_16X32, 16'h0003, 64, -1);
    wr(IDX_CHAR_CONTROL, 8'h00);
    glyph(FMT_32X32, 16'h0002, 128, 1024);
    chk(nfg, pop);
    wr(IDX_CHAR_CONTROL, 8'h04);
    @(negedge clk);
    chk(tw, 16'd16);
    wr(IDX_CURSOR_CONTROL, 8'h1e);
    wr(IDX_GCUR_X_LOW, 8'h34);
    wr(IDX_GCUR_X_HIGH, 8'h12);
    wr(IDX_GCUR_COLOUR_ZERO, 8'ha5);
    wr(IDX_GCUR_COLOUR_ONE, 8'h5a);
    @(negedge clk);
    chk({tshow, gshow, gbase, gx}, {2'b11, 10'h300, 16'h1234});
    for (k = 0; k < 4; k++)
    begin
      @(posedge clk);
      gi <= k[1:0];
      @(posedge clk);
      @(negedge clk);
      chk(gcol, ce[k]);
    end
    wr(IDX_SCAN_CONTROL, 8'h88);
    @(negedge clk);
    chk({tshow, gshow, picture_in_picture}, 3'b000);
    wr(IDX_SCAN_CONTROL, 8'h80);
    @(negedge clk);
    chk({tshow, gshow, picture_in_picture}, 3'b111);
    wr(IDX_CURSOR_CONTROL, 8'h1f);
    frm <= 1'b1;
    repeat (16) @(posedge clk);
    frm <= 1'b0;
    @(negedge clk);
    chk(tshow, 1'b0);
    $display("Cursor test done");
    finish_test;
  end
endmodule
